// ### csq_pkg.sv
/*
 Constants and state type for the charge-state sequencer.
 Assumes the analog comparators deliver asynchronous levels to the logic.
*/
// How it works
// - Bulk charge drives status code 01
// - Battery at 95 percent leaves bulk
// - Over charge entry drives status code 10
// - Near full current drives status code 11
// - Near full never stops charging early
// - Fourteen bit counter times over charge
// - Timer starts on over charge entry
// - Expiry pulls request pin low, ends cycle
// - Both amplifiers enabled during bulk charge
// - Rising request pin starts ordered charge states
// - Below trickle threshold stays trickle, code 00
// - Above trickle threshold and below 95% enters bulk
// - Timer oscillator runs only in over charge
package csq_pkg;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int unsigned TMR_W = 14;
  localparam logic [13:0] TMR_RST = 14'h0000;
  localparam logic [13:0] TMR_LAST = 14'h3FFF;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic [2:0] PIPE_RST = 3'h0;

  // ****************************************************************
  // Status codes, {high bit, low bit}
  // ****************************************************************
  localparam logic [1:0] CODE_TRICKLE = 2'h0;
  localparam logic [1:0] CODE_BULK = 2'h1;
  localparam logic [1:0] CODE_OVER = 2'h2;
  localparam logic [1:0] CODE_TOPOFF = 2'h3;

  typedef enum logic [2:0] {
    CSQ_IDLE,
    CSQ_TRICKLE,
    CSQ_BULK,
    CSQ_OVER,
    CSQ_DONE
  } csq_state_t;

endpackage : csq_pkg

// ### csq_sync.sv
/*
 Three-stage input conditioner for one asynchronous level.
 Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/1ps
module csq_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and filtered level out
  input wire logic din,
  output logic dout
);

  logic [2:0] pipe_r;
  logic [2:0] pipe_nxt;
  logic dout_r;
  logic dout_nxt;

  // Shift chain; only the last two stages are compared
  always_comb begin
    pipe_nxt = {pipe_r[1:0], din};
    dout_nxt = (pipe_r[2] == pipe_r[1]) ? pipe_r[1] : dout_r;
  end

  // Register stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pipe_r <= csq_pkg::PIPE_RST;
      dout_r <= 1'b0;
    end else begin
      pipe_r <= pipe_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;

endmodule : csq_sync

// ### csq_seq.sv
/*
 Charge-state sequencer with 14-bit over charge timer.
 Assumes comparator results arrive as asynchronous logic levels and the
 timer oscillator arrives as an asynchronous square wave on a pin.
 The request pin is open drain: the host pulls it up, we only pull low.
*/
`timescale 1ns/1ps
module csq_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Charge request pin, open drain
  input wire logic charge_request_pin_i,
  output logic charge_request_pin_o,
  output logic charge_request_pin_oe_n,
  // Comparator results from the analog side
  input wire logic trickle_above_thr, // trickle_threshold_sense > 2.05V
  input wire logic battery_at_95pct, // battery_sense_input >= 95% of reference
  input wire logic near_full_cmp, // current_sense_output > near_full_threshold_pin
  // Timer oscillator square wave, from timer_capacitor / timing_resistor
  input wire logic timer_osc_in,
  // Status code, open drain (oe_n low pulls the pin low)
  output logic state_code_low_bit_o,
  output logic state_code_low_bit_oe_n,
  output logic state_code_high_bit_o,
  output logic state_code_high_bit_oe_n,
  // Analog control
  output logic voltage_amp_en,
  output logic current_amp_en,
  output logic timer_osc_en,
  output logic charge_active
);

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  logic req_s;
  logic trk_s;
  logic v95_s;
  logic nf_s;
  logic osc_s;
  logic [4:0] raw_in;
  logic [4:0] syn_out;

  assign raw_in = {timer_osc_in, near_full_cmp, battery_at_95pct, trickle_above_thr, charge_request_pin_i};

  // One conditioner per asynchronous input
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      csq_sync u_sync (
        .clk(clk),
        .rst(rst),
        .din(raw_in[gi]),
        .dout(syn_out[gi])
      );
    end
  endgenerate

  assign req_s = syn_out[0];
  assign trk_s = syn_out[1];
  assign v95_s = syn_out[2];
  assign nf_s = syn_out[3];
  assign osc_s = syn_out[4];

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  csq_pkg::csq_state_t state_r;
  csq_pkg::csq_state_t state_nxt;
  logic req_d_r;
  logic req_d_nxt;
  logic osc_d_r;
  logic osc_d_nxt;
  logic topoff_r;
  logic topoff_nxt;
  logic [13:0] tmr_r;
  logic [13:0] tmr_nxt;
  logic pull_r;
  logic pull_nxt;
  logic [1:0] code_r;
  logic [1:0] code_nxt;
  logic vamp_r;
  logic vamp_nxt;
  logic camp_r;
  logic camp_nxt;
  logic oscen_r;
  logic oscen_nxt;
  logic act_r;
  logic act_nxt;
  logic req_rise;
  logic osc_tick;

  // Pin reads back low while we pull it, so a rising edge only comes
  // from the host once our pull has been released
  assign req_rise = req_s & ~req_d_r;
  assign osc_tick = osc_s & ~osc_d_r & (state_r == csq_pkg::CSQ_OVER);

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    topoff_nxt = topoff_r;
    tmr_nxt = tmr_r;
    pull_nxt = pull_r;
    req_d_nxt = req_s;
    osc_d_nxt = osc_s;
    if (req_rise) begin
      // Restart from the first state; counter starts fresh
      state_nxt = csq_pkg::CSQ_TRICKLE;
      tmr_nxt = csq_pkg::TMR_RST;
      topoff_nxt = 1'b0;
      pull_nxt = 1'b0;
    end else begin
      case (state_r)
        csq_pkg::CSQ_IDLE: begin
          state_nxt = csq_pkg::CSQ_IDLE;
        end
        csq_pkg::CSQ_TRICKLE: begin
          if (trk_s && !v95_s) begin
            state_nxt = csq_pkg::CSQ_BULK;
          end else if (trk_s && v95_s) begin
            // Already charged past 95%: bulk passes through in one cycle
            state_nxt = csq_pkg::CSQ_BULK;
          end else begin
            state_nxt = csq_pkg::CSQ_TRICKLE;
          end
        end
        csq_pkg::CSQ_BULK: begin
          if (v95_s) begin
            state_nxt = csq_pkg::CSQ_OVER;
            tmr_nxt = csq_pkg::TMR_RST;
            topoff_nxt = 1'b0;
          end
        end
        csq_pkg::CSQ_OVER: begin
          // Near full only changes the code; the timer alone ends charging
          if (nf_s) begin
            topoff_nxt = 1'b1;
          end
          if (osc_tick) begin
            if (tmr_r == csq_pkg::TMR_LAST) begin
              state_nxt = csq_pkg::CSQ_DONE;
              pull_nxt = 1'b1;
            end else begin
              tmr_nxt = 14'(tmr_r + 14'h0001);
            end
          end
        end
        csq_pkg::CSQ_DONE: begin
          pull_nxt = 1'b1;
        end
        default: begin
          state_nxt = csq_pkg::CSQ_IDLE;
        end
      endcase
    end
  end

  // Output decode from the next state, so outputs change together with the state register
  always_comb begin
    code_nxt = csq_pkg::CODE_TRICKLE;
    vamp_nxt = 1'b0;
    camp_nxt = 1'b1;
    oscen_nxt = 1'b0;
    act_nxt = 1'b0;
    case (state_nxt)
      csq_pkg::CSQ_TRICKLE: begin
        code_nxt = csq_pkg::CODE_TRICKLE;
        act_nxt = 1'b1;
      end
      csq_pkg::CSQ_BULK: begin
        code_nxt = csq_pkg::CODE_BULK;
        vamp_nxt = 1'b1;
        camp_nxt = 1'b1;
        act_nxt = 1'b1;
      end
      csq_pkg::CSQ_OVER: begin
        code_nxt = topoff_nxt ? csq_pkg::CODE_TOPOFF : csq_pkg::CODE_OVER;
        vamp_nxt = 1'b1;
        oscen_nxt = 1'b1;
        act_nxt = 1'b1;
      end
      csq_pkg::CSQ_DONE: begin
        code_nxt = csq_pkg::CODE_OVER;
      end
      default: begin
        code_nxt = csq_pkg::CODE_TRICKLE;
      end
    endcase
  end

  // Register all state and outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= csq_pkg::CSQ_IDLE;
      req_d_r <= 1'b0;
      osc_d_r <= 1'b0;
      topoff_r <= 1'b0;
      tmr_r <= csq_pkg::TMR_RST;
      pull_r <= 1'b0;
      code_r <= csq_pkg::CODE_TRICKLE;
      vamp_r <= 1'b0;
      camp_r <= 1'b0;
      oscen_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_d_r <= req_d_nxt;
      osc_d_r <= osc_d_nxt;
      topoff_r <= topoff_nxt;
      tmr_r <= tmr_nxt;
      pull_r <= pull_nxt;
      code_r <= code_nxt;
      vamp_r <= vamp_nxt;
      camp_r <= camp_nxt;
      oscen_r <= oscen_nxt;
      act_r <= act_nxt;
    end
  end

  // ****************************************************************
  // Pin drive: outputs held at 0, enables low only when pulling low
  // ****************************************************************
  assign charge_request_pin_o = 1'b0;
  assign charge_request_pin_oe_n = ~pull_r;
  assign state_code_low_bit_o = 1'b0;
  assign state_code_low_bit_oe_n = code_r[0];
  assign state_code_high_bit_o = 1'b0;
  assign state_code_high_bit_oe_n = code_r[1];
  assign voltage_amp_en = vamp_r;
  assign current_amp_en = camp_r;
  assign timer_osc_en = oscen_r;
  assign charge_active = act_r;

endmodule : csq_seq

// ### csq_seq_monitor.sv
/*
 Checker on the sequencer top ports.
 Assumes one clock and an async high reset.
*/
`timescale 1ns/1ps
module csq_seq_monitor (
  // Clock, reset and comparators
  input logic clk,
  input logic rst,
  input logic trickle_above_thr,
  input logic battery_at_95pct,
  // Pins and enables
  input logic charge_request_pin_oe_n,
  input logic state_code_low_bit_oe_n,
  input logic state_code_high_bit_oe_n,
  input logic voltage_amp_en,
  input logic current_amp_en,
  input logic timer_osc_en,
  input logic charge_active
);
  // State as seen from the enables
  wire lo = state_code_low_bit_oe_n;
  wire hi = state_code_high_bit_oe_n;
  wire bulk = voltage_amp_en & ~timer_osc_en;
  wire trk = charge_active & ~voltage_amp_en;
  wire done = ~charge_request_pin_oe_n & ~charge_active & ~timer_osc_en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  bulk_code_a: assert property (bulk |-> !hi && lo && current_amp_en)
    else $error("bulk code");
  over_code_a: assert property (timer_osc_en |-> hi && charge_active)
    else $error("over code");
  trickle_code_a: assert property (trk |-> !hi && !lo)
    else $error("trickle code");
  // Two samples in a row survive the input filter; the state answers four to five cycles later
  bulk_exit_a: assert property ((bulk && battery_at_95pct) [*2] |-> ##[1:5] timer_osc_en)
    else $error("bulk exit");
  bulk_entry_a: assert property ((trk && trickle_above_thr && !battery_at_95pct) [*2]
    |-> ##[1:5] voltage_amp_en) else $error("bulk entry");
  topoff_hold_a: assert property (timer_osc_en && lo |=> lo || !timer_osc_en)
    else $error("top off lost");
  expire_hold_a: assert property ($fell(charge_request_pin_oe_n) |-> (done && hi && !lo) [*8])
    else $error("expiry state");
  over_order_a: assert property ($rose(timer_osc_en) |-> $past(bulk))
    else $error("over order");
endmodule : csq_seq_monitor
bind csq_seq csq_seq_monitor i_csq_seq_monitor (.*);

// ### csq_host_model.sv
/*
 Host and battery sense stand-in.
 Assumes one bench process calls its tasks.
*/
`timescale 1ns/1ps
module csq_host_model (
  // Clock and device pull
  input logic clk,
  input logic charge_request_pin_oe_n,
  // Levels seen by the device
  output logic charge_request_pin_i,
  output logic trickle_above_thr,
  output logic battery_at_95pct,
  output logic near_full_cmp,
  output logic timer_osc_in
);
  logic host_low = 1'b1;
  // Pull-up wins unless host or device pulls low; starts low so the first rise is clean
  assign charge_request_pin_i = charge_request_pin_oe_n & ~host_low;
  initial {trickle_above_thr, battery_at_95pct, near_full_cmp, timer_osc_in} = 4'h0;
  // Low for four cycles, then the release edge starts a cycle
  task automatic req();
    @(posedge clk);
    #1 host_low = 1'b1;
    repeat (4) @(posedge clk);
    #1 host_low = 1'b0;
  endtask : req
  task automatic set(input logic t, input logic b, input logic n);
    @(posedge clk);
    #1 {trickle_above_thr, battery_at_95pct, near_full_cmp} = {t, b, n};
  endtask : set
  // Two cycles a half period: the shortest level the input filter keeps, and it keeps
  // a full 16384-edge expiry inside the run's cycle budget
  task automatic osc_edges(input int n);
    repeat (n) begin
      repeat (2) @(posedge clk);
      #1 timer_osc_in = 1'b1;
      repeat (2) @(posedge clk);
      #1 timer_osc_in = 1'b0;
    end
  endtask : osc_edges
endmodule : csq_host_model

// ### csq_seq_bench.sv
/*
 Self-checking bench for the charge sequencer.
 Assumes the host model owns all pin inputs.
*/
`timescale 1ns/1ps
module csq_seq_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic charge_request_pin_i, charge_request_pin_o, charge_request_pin_oe_n, timer_osc_in;
  logic trickle_above_thr, battery_at_95pct, near_full_cmp, voltage_amp_en, current_amp_en;
  logic state_code_low_bit_o, state_code_low_bit_oe_n, state_code_high_bit_o, state_code_high_bit_oe_n;
  logic timer_osc_en, charge_active;
  int errors = 0;
  int n_tests = 0;
  // Pin, code high and low, then voltage, current, oscillator, active
  wire [6:0] obs = {charge_request_pin_i, state_code_high_bit_oe_n, state_code_low_bit_oe_n,
    voltage_amp_en, current_amp_en, timer_osc_en, charge_active};
  always #2.5 clk = ~clk;
  csq_seq i_csq_seq (
    .clk(clk),
    .rst(rst),
    .charge_request_pin_i(charge_request_pin_i),
    .charge_request_pin_o(charge_request_pin_o),
    .charge_request_pin_oe_n(charge_request_pin_oe_n),
    .trickle_above_thr(trickle_above_thr),
    .battery_at_95pct(battery_at_95pct),
    .near_full_cmp(near_full_cmp),
    .timer_osc_in(timer_osc_in),
    .state_code_low_bit_o(state_code_low_bit_o),
    .state_code_low_bit_oe_n(state_code_low_bit_oe_n),
    .state_code_high_bit_o(state_code_high_bit_o),
    .state_code_high_bit_oe_n(state_code_high_bit_oe_n),
    .voltage_amp_en(voltage_amp_en),
    .current_amp_en(current_amp_en),
    .timer_osc_en(timer_osc_en),
    .charge_active(charge_active)
  );
  csq_host_model i_csq_host_model (
    .clk(clk),
    .charge_request_pin_oe_n(charge_request_pin_oe_n),
    .charge_request_pin_i(charge_request_pin_i),
    .trickle_above_thr(trickle_above_thr),
    .battery_at_95pct(battery_at_95pct),
    .near_full_cmp(near_full_cmp),
    .timer_osc_in(timer_osc_in)
  );
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Eight cycles clear the input latency; look 1 ns after the edge, once outputs settle
  task automatic see(input logic [6:0] exp);
    repeat (8) @(posedge clk);
    #1;
    chk(obs, exp);
  endtask : see
  task automatic summarize();
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  // Oscillator edges before over charge must not count
  task automatic sc_start();
    i_csq_host_model.req();
    see(7'h45);
    i_csq_host_model.set(1'b1, 1'b0, 1'b0);
    see(7'h5D);
    i_csq_host_model.osc_edges(50);
    see(7'h5D);
    i_csq_host_model.set(1'b1, 1'b1, 1'b0);
    see(7'h6F);
    i_csq_host_model.osc_edges(200);
  endtask : sc_start
  // Stale counts from the aborted cycle would expire early
  task automatic sc_restart();
    i_csq_host_model.set(1'b0, 1'b0, 1'b0);
    i_csq_host_model.req();
    see(7'h45);
    i_csq_host_model.set(1'b1, 1'b1, 1'b1);
    see(7'h7F);
    i_csq_host_model.set(1'b1, 1'b1, 1'b0);
    see(7'h7F);
    i_csq_host_model.osc_edges(16383);
    see(7'h7F);
    // Expiry must fall on exactly the 16384th edge, and the pull must then stay
    i_csq_host_model.osc_edges(1);
    see(7'h24);
    see(7'h24);
    chk({4'h0, charge_request_pin_o, state_code_high_bit_o, state_code_low_bit_o}, 7'h00);
  endtask : sc_restart
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    see(7'h04);
    sc_start();
    sc_restart();
    summarize();
  end
  // About 67k cycles of oscillator edges; 450 us (90k cycles) leaves margin
  initial begin
    #450000;
    errors++;
    summarize();
  end
endmodule : csq_seq_bench
